/* File: pkg/psa_alu_map.svh */
// Encoding fields, opcode values and lane widths of the packed sub-word datapath
`ifndef PSA_ALU_MAP_SVH
`define PSA_ALU_MAP_SVH

// Instruction field positions
`define PSA_OPC_MSB 6
`define PSA_OPC_LSB 0
`define PSA_F3_MSB 14
`define PSA_F3_LSB 12
`define PSA_F5_MSB 31
`define PSA_F5_LSB 27
`define PSA_F7_MSB 31
`define PSA_F7_LSB 25
`define PSA_FBIT 26
`define PSA_IMM_HI_MSB 24
`define PSA_IMM_HI_LSB 20
`define PSA_IMM_LO_BIT 25

// Major opcodes and word multiply-accumulate codes
`define PSA_OPC_SIMD 7'h7b
`define PSA_OPC_MAC 7'h2b
`define PSA_F3_MAC 3'h3
`define PSA_F7_MAC 7'h48
`define PSA_F7_MSU 7'h49

// Packed group function codes
`define PSA_F5_ABS 5'h0e
`define PSA_F5_EXT 5'h17
`define PSA_F5_SHUF 5'h18
`define PSA_F5_SHUF2 5'h19
`define PSA_F5_PACK 5'h1a
`define PSA_F5_PACKB 5'h1b
`define PSA_F5_SHUFI_TOP 3'h7

// Sub-function selectors
`define PSA_F3_SCI_H 3'h6
`define PSA_F3_SCI_B 3'h7
`define PSA_F3_INSERT 2'h2
`define PSA_F3_PAIR 2'h0

// Lane widths and shuffle control positions
`define PSA_BYTE_W 8
`define PSA_HALF_W 16
`define PSA_SHUF2_H_HI 17
`define PSA_SHUF2_H_LO 1
`define PSA_SHUF2_B3 26
`define PSA_SHUF2_B2 18
`define PSA_SHUF2_B1 10
`define PSA_SHUF2_B0 2

`endif

/* File: pkg/psa_pkg.sv */
// Types shared by the packed sub-word datapath
package psa_pkg;

	// Per-lane operation, ordered as the low four function-code bits
	typedef enum logic [3:0] {
		PSA_LANE_ADD, PSA_LANE_SUB, PSA_LANE_AVG, PSA_LANE_AVGU,
		PSA_LANE_MIN, PSA_LANE_MINU, PSA_LANE_MAX, PSA_LANE_MAXU,
		PSA_LANE_SRL, PSA_LANE_SRA, PSA_LANE_SLL, PSA_LANE_OR,
		PSA_LANE_XOR, PSA_LANE_AND, PSA_LANE_ABS
	} psa_lane_op_type;

	// Instruction class after decode
	typedef enum logic [3:0] {
		PSA_CLS_NONE, PSA_CLS_LANE, PSA_CLS_EXTRACT, PSA_CLS_INSERT,
		PSA_CLS_DOT, PSA_CLS_SHUF, PSA_CLS_SHUF_IMM, PSA_CLS_SHUF2,
		PSA_CLS_PACK, PSA_CLS_PACK_BYTE, PSA_CLS_MAC
	} psa_class_type;

endpackage

/* File: testbench/psa_alu_asserts.sv */
// Port-level checks for the packed sub-word datapath
`timescale 1ns/1ps
`include "psa_alu_map.svh"

module psa_alu_asserts #(
	parameter bit customExtensionEnable = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Issue
	input wire logic issueValid,
	input wire logic [31:0] instr,
	input wire logic [31:0] rs1Val,
	input wire logic [31:0] rs2Val,
	input wire logic [31:0] destOld,
	// Writeback
	input wire logic resultValid,
	input wire logic [31:0] result,
	input wire logic illegalInsn,
	input wire logic destRead
);
	logic [31:0] a1;
	logic [31:0] b1;
	logic [31:0] d1;
	logic [1:0] k1;

	// Issue field decode
	wire logic [4:0] f5 = instr[31:27];
	wire logic [2:0] f3 = instr[14:12];
	wire logic simd = customExtensionEnable && issueValid && instr[6:0] == `PSA_OPC_SIMD
		&& !instr[26];
	wire logic mac = customExtensionEnable && issueValid && instr[6:0] == `PSA_OPC_MAC
		&& f3 == `PSA_F3_MAC;

	// Operands of the issue, seen in the answer cycle
	always_ff @(posedge clk) begin
		a1 <= rs1Val;
		b1 <= rs2Val;
		d1 <= destOld;
		k1 <= {instr[20], instr[25]};
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_answer;
		issueValid |=> resultValid != illegalInsn;
	endproperty
	a_answer: assert property (p_answer) else $error("issue not answered once");
	property p_quiet;
		!issueValid |=> !resultValid && !illegalInsn && $stable(result);
	endproperty
	a_quiet: assert property (p_quiet) else $error("output moved without issue");
	property p_off;
		!customExtensionEnable && issueValid |=> illegalInsn && result == 32'h0;
	endproperty
	a_off: assert property (p_off) else $error("disabled build accepted issue");
	property p_mac;
		mac && instr[31:25] == `PSA_F7_MAC |=> destRead && result == d1 + a1 * b1;
	endproperty
	a_mac: assert property (p_mac) else $error("multiply-accumulate wrong");
	property p_msu;
		mac && instr[31:25] == `PSA_F7_MSU |=> destRead && result == d1 - a1 * b1;
	endproperty
	a_msu: assert property (p_msu) else $error("multiply-subtract wrong");
	property p_add_h;
		simd && f5 == 5'h00 && f3 == 3'h0 |=>
			result == {a1[31:16] + b1[31:16], a1[15:0] + b1[15:0]};
	endproperty
	a_add_h: assert property (p_add_h) else $error("half add wrong");
	property p_sc_b;
		simd && f5 == 5'h00 && f3 == 3'h5 |=> result == {a1[31:24] + b1[7:0],
			a1[23:16] + b1[7:0], a1[15:8] + b1[7:0], a1[7:0] + b1[7:0]};
	endproperty
	a_sc_b: assert property (p_sc_b) else $error("byte scalar add wrong");
	property p_ins_b;
		simd && f5 == `PSA_F5_EXT && f3 == 3'h5 |=> destRead && result ==
			((d1 & ~(32'hff << {k1, 3'h0})) | ({24'h0, a1[7:0]} << {k1, 3'h0}));
	endproperty
	a_ins_b: assert property (p_ins_b) else $error("byte insert wrong");
	property p_pack;
		simd && f5 == `PSA_F5_PACK && f3 == 3'h0 |=> result == {a1[15:0], b1[15:0]};
	endproperty
	a_pack: assert property (p_pack) else $error("half pack wrong");
	property p_dr;
		destRead |-> resultValid;
	endproperty
	a_dr: assert property (p_dr) else $error("dest read flag alone");
endmodule

bind psa_alu psa_alu_asserts #(.customExtensionEnable(customExtensionEnable)) chk (
	.clk(clk), .rst_b(rst_b), .issueValid(issueValid), .instr(instr), .rs1Val(rs1Val),
	.rs2Val(rs2Val), .destOld(destOld), .resultValid(resultValid), .result(result),
	.illegalInsn(illegalInsn), .destRead(destRead));

/* File: testbench/psa_alu_tb_top.sv */
// Self-checking bench for the packed sub-word datapath
`timescale 1ns/1ps
`include "psa_alu_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin error_cnt++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end

module psa_alu_tb_top;
	localparam logic [5:0] R2 = 6'h04;
	logic clk, rst_b, load, go, issueValid, resultValid, illegalInsn, destRead, offIll;
	logic [31:0] loadA, loadB, dOld, goInstr, instr, rs1Val, rs2Val, destOld, result;
	int error_cnt = 0;
	int checked = 0;
	int cyc = 0;

	// Core side model
	psa_core_model model (.clk(clk), .load(load), .loadA(loadA), .loadB(loadB),
		.loadD(dOld), .go(go), .goInstr(goInstr), .issueValid(issueValid), .instr(instr),
		.rs1Val(rs1Val), .rs2Val(rs2Val), .destOld(destOld), .resultValid(resultValid),
		.result(result));
	// Datapath with the extension built in
	psa_alu #(.customExtensionEnable(1'b1)) DUT (.clk(clk), .rst_b(rst_b),
		.issueValid(issueValid), .instr(instr), .rs1Val(rs1Val), .rs2Val(rs2Val),
		.destOld(destOld), .resultValid(resultValid), .result(result),
		.illegalInsn(illegalInsn), .destRead(destRead));
	// Same stream into a build without it; must refuse everything
	psa_alu #(.customExtensionEnable(1'b0)) dutOff (.clk(clk), .rst_b(rst_b),
		.issueValid(issueValid), .instr(instr), .rs1Val(rs1Val), .rs2Val(rs2Val),
		.destOld(destOld), .resultValid(), .result(), .illegalInsn(offIll), .destRead());

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 2000) begin
			error_cnt++;
			complete_run();
		end
	end

	// Packed group word, rs1 = x1, rd = x3, rs2 field or immediate from imm
	function automatic logic [31:0] enc(input logic [4:0] f5, input logic [2:0] f3,
		input logic [5:0] imm);
		enc = {f5, 1'b0, imm[0], imm[5:1], 5'h01, f3, 5'h03, `PSA_OPC_SIMD};
	endfunction

	// One issue; f is {illegal, dest read}
	task automatic run(input logic [31:0] ins, a, b, exp, input logic [1:0] f);
		int n;
		n = 0;
		@(posedge clk);
		#2;
		load = 1'b1;
		loadA = a;
		loadB = b;
		@(posedge clk);
		#2;
		load = 1'b0;
		go = 1'b1;
		goInstr = ins;
		@(posedge clk);
		#2;
		go = 1'b0;
		while (resultValid !== 1'b1 && illegalInsn !== 1'b1 && n < 8) begin
			@(posedge clk);
			#2;
			n++;
		end
		`CHK({resultValid, illegalInsn}, {~f[1], f[1]})
		`CHK(result, exp)
		`CHK(destRead, f[0])
		`CHK(offIll, 1'b1)
	endtask

	task automatic t_lanes;
		run(enc(5'h00, 3'h1, R2), 32'h80ff7f01, 32'h80017f01, 32'h0000fe02, 2'h0);
		run(enc(5'h00, 3'h0, R2), 32'hffff8000, 32'h00018000, 32'h00000000, 2'h0);
		run(enc(5'h00, 3'h5, R2), 32'h01020304, 32'hffffff10, 32'h11121314, 2'h0);
		run(enc(5'h00, 3'h4, R2), 32'h00010002, 32'h1234ffff, 32'h00000001, 2'h0);
		run(enc(5'h00, 3'h6, 6'h2a), 32'h00010002, 32'h0, 32'hffebffec, 2'h0);
		run(enc(5'h02, 3'h1, R2), 32'hc0020406, 32'hc0020406, 32'hc0020406, 2'h0);
		run(enc(5'h03, 3'h1, R2), 32'hc0020406, 32'hc0020406, 32'h40020406, 2'h0);
		run(enc(5'h01, 3'h0, R2), 32'h00010000, 32'h00020001, 32'hffffffff, 2'h0);
	endtask

	task automatic t_shift_cmp;
		run(enc(5'h08, 3'h0, R2), 32'h80008000, 32'h00010004, 32'h40000800, 2'h0);
		run(enc(5'h09, 3'h1, R2), 32'h80808080, 32'h00010207, 32'h80c0e0ff, 2'h0);
		run(enc(5'h0a, 3'h7, 6'h03), 32'h01020381, 32'h0, 32'h08101808, 2'h0);
		run(enc(5'h04, 3'h0, R2), 32'h80000005, 32'h7fff0003, 32'h80000003, 2'h0);
		run(enc(5'h05, 3'h0, R2), 32'h80000005, 32'h7fff0003, 32'h7fff0003, 2'h0);
		run(enc(5'h06, 3'h1, R2), 32'h80017f00, 32'h7f02ff01, 32'h7f027f01, 2'h0);
		run(enc(5'h07, 3'h1, R2), 32'h80017f00, 32'h7f02ff01, 32'h8002ff01, 2'h0);
	endtask

	task automatic t_logic;
		run(enc(5'h0b, 3'h0, R2), 32'hf0f00000, 32'h0f0f1234, 32'hffff1234, 2'h0);
		run(enc(5'h0c, 3'h1, R2), 32'hff00ff00, 32'h0f0f0f0f, 32'hf00ff00f, 2'h0);
		run(enc(5'h0d, 3'h0, R2), 32'h12345678, 32'hff0000ff, 32'h12000078, 2'h0);
		run(enc(5'h0e, 3'h1, 6'h00), 32'h80ff0501, 32'h0, 32'h80010501, 2'h0);
	endtask

	task automatic t_lane_moves;
		dOld = 32'h11223344;
		run(enc(5'h17, 3'h1, 6'h01), 32'h11228344, 32'h0, 32'hffffff83, 2'h0);
		run(enc(5'h17, 3'h0, 6'h01), 32'h80001234, 32'h0, 32'hffff8000, 2'h0);
		run(enc(5'h17, 3'h3, 6'h3d), 32'h11228344, 32'h0, 32'h00000083, 2'h0);
		run(enc(5'h17, 3'h5, 6'h02), 32'h000000ab, 32'h0, 32'h11ab3344, 2'h1);
		run(enc(5'h17, 3'h4, 6'h01), 32'h0000cdef, 32'h0, 32'hcdef3344, 2'h1);
		run(enc(5'h1b, 3'h1, R2), 32'h000000ab, 32'h000000cd, 32'habcd3344, 2'h1);
		run(enc(5'h1b, 3'h0, R2), 32'h000000ab, 32'h000000cd, 32'h1122abcd, 2'h1);
		run(enc(5'h1a, 3'h0, R2), 32'h1111aaaa, 32'h2222bbbb, 32'haaaabbbb, 2'h0);
		run(enc(5'h1a, 3'h1, R2), 32'h1111aaaa, 32'h2222bbbb, 32'h11112222, 2'h0);
	endtask

	task automatic t_dot_shuffle;
		dOld = 32'h00000100;
		run(enc(5'h11, 3'h1, R2), 32'hff020304, 32'hff010203, 32'hffffff15, 2'h0);
		run(enc(5'h12, 3'h1, R2), 32'hff020304, 32'hff010203, 32'h00000015, 2'h0);
		run(enc(5'h15, 3'h0, R2), 32'hffff0002, 32'hfffd0004, 32'hfffd010b, 2'h1);
		run(enc(5'h15, 3'h7, 6'h3f), 32'h01020304, 32'h0, 32'h000000f6, 2'h1);
		run(enc(5'h10, 3'h4, R2), 32'h00020003, 32'h0000ffff, 32'h0004fffb, 2'h0);
		run(enc(5'h18, 3'h6, 6'h01), 32'haaaabbbb, 32'h0, 32'hbbbbaaaa, 2'h0);
		run(enc(5'h18, 3'h1, R2), 32'h44332211, 32'h00010203, 32'h11223344, 2'h0);
		for (int n = 0; n < 4; n++) begin
			run(enc(5'h1c + 5'(n), 3'h7, 6'h06), 32'h44332211, 32'h0,
				{8'(32'h44332211 >> (8 * n)), 24'h112233}, 2'h0);
		end
		dOld = 32'hddccbbaa;
		run(enc(5'h19, 3'h1, R2), 32'h44332211, 32'h04010603, 32'h11bb33dd, 2'h1);
		run(enc(5'h19, 3'h0, R2), 32'h44332211, 32'h00020001, 32'h2211ddcc, 2'h1);
	endtask

	task automatic t_word_mac;
		dOld = 32'h00000010;
		run({`PSA_F7_MAC, 5'h02, 5'h01, `PSA_F3_MAC, 5'h03, `PSA_OPC_MAC},
			32'h00010003, 32'h00000005, 32'h0005001f, 2'h1);
		run({`PSA_F7_MSU, 5'h02, 5'h01, `PSA_F3_MAC, 5'h03, `PSA_OPC_MAC},
			32'h00010003, 32'h00000005, 32'hfffb0001, 2'h1);
		run({7'h4a, 5'h02, 5'h01, `PSA_F3_MAC, 5'h03, `PSA_OPC_MAC},
			32'h00010003, 32'h00000005, 32'h0, 2'h2);
		run(enc(5'h00, 3'h1, R2) | 32'h04000000, 32'h1, 32'h1, 32'h0, 2'h2);
	endtask

	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Main sequence
	initial begin
		rst_b = 1'b0;
		load = 1'b0;
		go = 1'b0;
		loadA = 32'h0;
		loadB = 32'h0;
		dOld = 32'h0;
		goInstr = 32'h0;
		repeat (2) @(posedge clk);
		#2;
		rst_b = 1'b1;
		repeat (3) @(posedge clk);
		t_lanes();
		t_shift_cmp();
		t_logic();
		t_lane_moves();
		t_dot_shuffle();
		t_word_mac();
		complete_run();
	end
endmodule

/* File: testbench/psa_core_model.sv */
// Decode stage and register file that feed the datapath
`timescale 1ns/1ps

module psa_core_model (
	// Clock
	input wire logic clk,
	// Bench control
	input wire logic load,
	input wire logic [31:0] loadA,
	input wire logic [31:0] loadB,
	input wire logic [31:0] loadD,
	input wire logic go,
	input wire logic [31:0] goInstr,
	// Issue
	output logic issueValid,
	output logic [31:0] instr,
	output logic [31:0] rs1Val,
	output logic [31:0] rs2Val,
	output logic [31:0] destOld,
	// Writeback
	input wire logic resultValid,
	input wire logic [31:0] result
);
	logic [31:0] regs [0:31];
	logic [4:0] pendRd;

	initial begin
		issueValid = 1'b0;
		instr = 32'h0;
		rs1Val = 32'h0;
		rs2Val = 32'h0;
		destOld = 32'h0;
		pendRd = 5'h00;
		for (int i = 0; i < 32; i++) regs[i] = 32'h0;
	end

	// Idle lines flip every cycle so stale operands are never mistaken for live ones
	always @(posedge clk) begin
		if (load) begin
			regs[1] <= loadA;
			regs[2] <= loadB;
			regs[3] <= loadD;
		end
		if (resultValid && pendRd != 5'h00) regs[pendRd] <= result;
		issueValid <= go;
		if (go) begin
			instr <= goInstr;
			rs1Val <= regs[goInstr[19:15]];
			rs2Val <= regs[goInstr[24:20]];
			destOld <= regs[goInstr[11:7]];
			pendRd <= goInstr[11:7];
		end else begin
			instr <= ~instr;
			rs1Val <= ~rs1Val;
			rs2Val <= ~rs2Val;
			destOld <= ~destOld;
		end
	end
endmodule

/* File: verilog/psa_alu.sv */
// Packed sub-word arithmetic datapath with word multiply-accumulate
`timescale 1ns/1ps
`include "psa_alu_map.svh"

module psa_alu import psa_pkg::*; #(
	parameter bit customExtensionEnable = 1'b1
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Issue from decode stage
	input wire logic issueValid,
	input wire logic [31:0] instr,
	input wire logic [31:0] rs1Val,
	input wire logic [31:0] rs2Val,
	input wire logic [31:0] destOld,
	// Writeback
	output logic resultValid,
	output logic [31:0] result,
	output logic illegalInsn,
	output logic destRead
);

	logic rstMeta_b;
	logic rstSync_b;
	logic [6:0] opcode;
	logic [2:0] f3;
	logic [4:0] f5;
	logic [6:0] f7;
	logic [5:0] six_bit_lane_immediate;
	logic isByte;
	logic isScalar;
	logic isImm;
	logic simdGrp;
	logic macGrp;
	logic f3Lane;
	logic laneOk;
	psa_class_type cls;
	psa_lane_op_type laneOp;
	logic immZero;
	logic [15:0] immHalf;
	logic [7:0] immByte;
	logic [31:0] op2Half;
	logic [31:0] op2Byte;
	logic [31:0] op2;
	logic [31:0] laneResByte;
	logic [31:0] laneResHalf;
	logic [7:0] extByte;
	logic [15:0] extHalf;
	logic [31:0] extractRes;
	logic [31:0] insertRes;
	logic [31:0] dotRes;
	logic [31:0] shufRes;
	logic [31:0] shufImmRes;
	logic [31:0] shuf2Res;
	logic [31:0] packRes;
	logic [31:0] packByteRes;
	logic [31:0] macRes;
	logic [31:0] product;
	logic [4:0] insShift;
	logic legal;
	logic readsDest;
	logic [31:0] next_result;

	// Pick byte lane idx of a word
	function automatic logic [7:0] psa_pick_byte(input logic [31:0] w, input logic [1:0] idx);
		psa_pick_byte = w[{idx, 3'h0} +: `PSA_BYTE_W];
	endfunction

	// Pick half-word lane idx of a word
	function automatic logic [15:0] psa_pick_half(input logic [31:0] w, input logic idx);
		psa_pick_half = idx ? w[31:16] : w[15:0];
	endfunction

	// Sum of lane products, each side signed or unsigned
	function automatic logic [31:0] psa_dot(input logic [31:0] a, input logic [31:0] b,
			input logic byteLanes, input logic aSigned, input logic bSigned);
		logic [31:0] acc;
		logic signed [31:0] ea;
		logic signed [31:0] eb;
		acc = '0;
		ea = '0;
		eb = '0;
		if (byteLanes) begin
			for (int i = 0; i < 4; i++) begin
				ea = {{24{aSigned & a[8*i+7]}}, a[8*i +: 8]};
				eb = {{24{bSigned & b[8*i+7]}}, b[8*i +: 8]};
				acc = acc + 32'(ea * eb);
			end
		end else begin
			for (int i = 0; i < 2; i++) begin
				ea = {{16{aSigned & a[16*i+15]}}, a[16*i +: 16]};
				eb = {{16{bSigned & b[16*i+15]}}, b[16*i +: 16]};
				acc = acc + 32'(ea * eb);
			end
		end
		psa_dot = acc;
	endfunction

	// Reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta_b <= 1'b0;
			rstSync_b <= 1'b0;
		end else begin
			rstMeta_b <= 1'b1;
			rstSync_b <= rstMeta_b;
		end
	end

	// Instruction fields
	assign opcode = instr[`PSA_OPC_MSB:`PSA_OPC_LSB];
	assign f3 = instr[`PSA_F3_MSB:`PSA_F3_LSB];
	assign f5 = instr[`PSA_F5_MSB:`PSA_F5_LSB];
	assign f7 = instr[`PSA_F7_MSB:`PSA_F7_LSB];
	assign six_bit_lane_immediate = {instr[`PSA_IMM_HI_MSB:`PSA_IMM_HI_LSB], instr[`PSA_IMM_LO_BIT]};
	assign isByte = f3[0];
	assign isScalar = f3[2];
	assign isImm = f3[2] & f3[1];

	// Group and class decode, all gated by the enable parameter
	assign simdGrp = customExtensionEnable && opcode == `PSA_OPC_SIMD
		&& !instr[`PSA_FBIT];
	assign macGrp = customExtensionEnable && opcode == `PSA_OPC_MAC && f3 == `PSA_F3_MAC
		&& (f7 == `PSA_F7_MAC || f7 == `PSA_F7_MSU);
	assign f3Lane = f3[2] | ~f3[1];
	assign laneOk = (f5 < `PSA_F5_ABS) ? f3Lane : (f5 == `PSA_F5_ABS && f3[2:1] == `PSA_F3_PAIR);
	assign cls = macGrp ? PSA_CLS_MAC :
		!simdGrp ? PSA_CLS_NONE :
		laneOk ? PSA_CLS_LANE :
		(f5 == `PSA_F5_EXT && !f3[2]) ? PSA_CLS_EXTRACT :
		(f5 == `PSA_F5_EXT && f3[2:1] == `PSA_F3_INSERT) ? PSA_CLS_INSERT :
		(f5[4:3] == 2'h2 && f5[1:0] != 2'h3 && f3Lane) ? PSA_CLS_DOT :
		(f5 == `PSA_F5_SHUF && (f3[2:1] == `PSA_F3_PAIR || f3 == `PSA_F3_SCI_H)) ?
			PSA_CLS_SHUF :
		(f5[4:2] == `PSA_F5_SHUFI_TOP && f3 == `PSA_F3_SCI_B) ? PSA_CLS_SHUF_IMM :
		(f5 == `PSA_F5_SHUF2 && f3[2:1] == `PSA_F3_PAIR) ? PSA_CLS_SHUF2 :
		(f5 == `PSA_F5_PACK && f3[2:1] == `PSA_F3_PAIR) ? PSA_CLS_PACK :
		(f5 == `PSA_F5_PACKB && f3[2:1] == `PSA_F3_PAIR) ? PSA_CLS_PACK_BYTE :
		PSA_CLS_NONE;
	assign legal = cls != PSA_CLS_NONE;
	assign laneOp = psa_lane_op_type'(f5[3:0]);

	// Forms that read the old destination need it forwarded by the core
	assign readsDest = cls == PSA_CLS_INSERT || cls == PSA_CLS_SHUF2
		|| cls == PSA_CLS_PACK_BYTE || cls == PSA_CLS_MAC
		|| (cls == PSA_CLS_DOT && f5[2]);

	// Unsigned lane forms take the immediate unsigned; dot codes alias these low bits
	assign immZero = cls == PSA_CLS_LANE && (laneOp == PSA_LANE_AVGU
		|| laneOp == PSA_LANE_MINU || laneOp == PSA_LANE_MAXU || laneOp == PSA_LANE_SRL
		|| laneOp == PSA_LANE_SRA || laneOp == PSA_LANE_SLL);
	assign immHalf = immZero ? {10'h000, six_bit_lane_immediate} : {{10{six_bit_lane_immediate[5]}}, six_bit_lane_immediate};
	assign immByte = immZero ? {2'h0, six_bit_lane_immediate} : {{2{six_bit_lane_immediate[5]}}, six_bit_lane_immediate};

	// Second operand: vector, replicated scalar or replicated immediate
	assign op2Half = isImm ? {2{immHalf}} :
		isScalar ? {2{rs2Val[15:0]}} : rs2Val;
	assign op2Byte = isImm ? {4{immByte}} :
		isScalar ? {4{rs2Val[7:0]}} : rs2Val;
	assign op2 = isByte ? op2Byte : op2Half;

	// Four byte lanes, all computed in the same cycle
	for (genvar i = 0; i < 4; i++) begin : g_byteLane
		psa_lane_unit #(
			.W(`PSA_BYTE_W)
		) u_lane (
			.op(laneOp),
			.a(rs1Val[8*i +: 8]),
			.b(op2Byte[8*i +: 8]),
			.y(laneResByte[8*i +: 8])
		);
	end

	// Two half-word lanes
	for (genvar i = 0; i < 2; i++) begin : g_halfLane
		psa_lane_unit #(
			.W(`PSA_HALF_W)
		) u_lane (
			.op(laneOp),
			.a(rs1Val[16*i +: 16]),
			.b(op2Half[16*i +: 16]),
			.y(laneResHalf[16*i +: 16])
		);
	end

	// Lane extract; lane index comes from raw immediate bits
	assign extByte = psa_pick_byte(rs1Val, six_bit_lane_immediate[1:0]);
	assign extHalf = psa_pick_half(rs1Val, six_bit_lane_immediate[0]);
	assign extractRes = isByte ? {{24{~f3[1] & extByte[7]}}, extByte} :
		{{16{~f3[1] & extHalf[15]}}, extHalf};

	// Lane insert keeps every other destination bit
	assign insShift = {six_bit_lane_immediate[1:0], 3'h0};
	assign insertRes = isByte ?
		((destOld & ~(32'h000000ff << insShift)) | ({24'h000000, rs1Val[7:0]} << insShift)) :
		(six_bit_lane_immediate[0] ? {rs1Val[15:0], destOld[15:0]} : {destOld[31:16], rs1Val[15:0]});

	// Dot product, plain or accumulating; funct bit 1 makes rs1 signed
	assign dotRes = psa_dot(rs1Val, op2, isByte, f5[1], f5[1] | f5[0])
		+ (f5[2] ? destOld : 32'h00000000);

	// Register shuffle; immediate half-word form uses bits I1 and I0
	assign shufRes = isByte ?
		{psa_pick_byte(rs1Val, rs2Val[25:24]), psa_pick_byte(rs1Val, rs2Val[17:16]),
			psa_pick_byte(rs1Val, rs2Val[9:8]), psa_pick_byte(rs1Val, rs2Val[1:0])} :
		isImm ? {psa_pick_half(rs1Val, six_bit_lane_immediate[1]), psa_pick_half(rs1Val, six_bit_lane_immediate[0])} :
		{psa_pick_half(rs1Val, rs2Val[16]), psa_pick_half(rs1Val, rs2Val[0])};

	// Immediate byte shuffle, top byte fixed by the variant number
	assign shufImmRes = {psa_pick_byte(rs1Val, f5[1:0]), psa_pick_byte(rs1Val, six_bit_lane_immediate[5:4]),
		psa_pick_byte(rs1Val, six_bit_lane_immediate[3:2]), psa_pick_byte(rs1Val, six_bit_lane_immediate[1:0])};

	// Two-source shuffle, control bit above each index field picks the source
	assign shuf2Res = isByte ?
		{psa_pick_byte(rs2Val[`PSA_SHUF2_B3] ? rs1Val : destOld, rs2Val[25:24]),
			psa_pick_byte(rs2Val[`PSA_SHUF2_B2] ? rs1Val : destOld, rs2Val[17:16]),
			psa_pick_byte(rs2Val[`PSA_SHUF2_B1] ? rs1Val : destOld, rs2Val[9:8]),
			psa_pick_byte(rs2Val[`PSA_SHUF2_B0] ? rs1Val : destOld, rs2Val[1:0])} :
		{psa_pick_half(rs2Val[`PSA_SHUF2_H_HI] ? rs1Val : destOld, rs2Val[16]),
			psa_pick_half(rs2Val[`PSA_SHUF2_H_LO] ? rs1Val : destOld, rs2Val[0])};

	// Packs; byte packs leave the other half of the destination alone
	assign packRes = isByte ? {rs1Val[31:16], rs2Val[31:16]} :
		{rs1Val[15:0], rs2Val[15:0]};
	assign packByteRes = isByte ? {rs1Val[7:0], rs2Val[7:0], destOld[15:0]} :
		{destOld[31:16], rs1Val[7:0], rs2Val[7:0]};

	// Word multiply-accumulate keeps only the low product word
	assign product = 32'(rs1Val * rs2Val);
	assign macRes = (f7 == `PSA_F7_MSU) ? destOld - product : destOld + product;

	// Result select by class
	always_comb begin
		case (cls)
			PSA_CLS_LANE: next_result = isByte ? laneResByte : laneResHalf;
			PSA_CLS_EXTRACT: next_result = extractRes;
			PSA_CLS_INSERT: next_result = insertRes;
			PSA_CLS_DOT: next_result = dotRes;
			PSA_CLS_SHUF: next_result = shufRes;
			PSA_CLS_SHUF_IMM: next_result = shufImmRes;
			PSA_CLS_SHUF2: next_result = shuf2Res;
			PSA_CLS_PACK: next_result = packRes;
			PSA_CLS_PACK_BYTE: next_result = packByteRes;
			PSA_CLS_MAC: next_result = macRes;
			default: next_result = 32'h00000000;
		endcase
	end

	// Writeback stage; one result per accepted issue, one cycle later
	always_ff @(posedge clk or negedge rstSync_b) begin
		if (!rstSync_b) begin
			resultValid <= 1'b0;
			illegalInsn <= 1'b0;
			destRead <= 1'b0;
			result <= 32'h00000000;
		end else begin
			resultValid <= issueValid & legal;
			illegalInsn <= issueValid & ~legal;
			destRead <= issueValid & legal & readsDest;
			if (issueValid) begin
				result <= next_result;
			end
		end
	end

endmodule

/* File: verilog/psa_lane_unit.sv */
// One independent lane of the packed arithmetic unit
`timescale 1ns/1ps

module psa_lane_unit import psa_pkg::*; #(
	parameter int W = 8
) (
	// Operation
	input wire psa_lane_op_type op,
	// Lane operands
	input wire logic [W-1:0] a,
	input wire logic [W-1:0] b,
	// Lane result
	output logic [W-1:0] y
);

	localparam int SW = $clog2(W);

	logic [W-1:0] sum;
	logic [W-1:0] diff;
	logic [SW-1:0] shamt;

	// Sums wrap at lane width, so no carry leaves the lane
	assign sum = a + b;
	assign diff = a - b;
	assign shamt = b[SW-1:0];

	// Lane function select
	always_comb begin
		case (op)
			PSA_LANE_ADD: y = sum;
			PSA_LANE_SUB: y = diff;
			PSA_LANE_AVG: y = {sum[W-1], sum[W-1:1]};
			PSA_LANE_AVGU: y = {1'b0, sum[W-1:1]};
			PSA_LANE_MIN: y = ($signed(a) < $signed(b)) ? a : b;
			PSA_LANE_MINU: y = (a < b) ? a : b;
			PSA_LANE_MAX: y = ($signed(a) > $signed(b)) ? a : b;
			PSA_LANE_MAXU: y = (a > b) ? a : b;
			PSA_LANE_SRL: y = a >> shamt;
			PSA_LANE_SRA: y = W'($signed(a) >>> shamt);
			PSA_LANE_SLL: y = a << shamt;
			PSA_LANE_OR: y = a | b;
			PSA_LANE_XOR: y = a ^ b;
			PSA_LANE_AND: y = a & b;
			PSA_LANE_ABS: y = a[W-1] ? W'(-a) : a;
			default: y = '0;
		endcase
	end

endmodule
